//--- verilog/spi_eeprom_core.sv
// serial eeprom command logic: status register, array read and array write start
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_core #(
	parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES_DEFAULT
) (
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire logic        chip_select_b,
	input  wire logic        serial_clock,
	input  wire logic        serial_in,
	input  wire logic        write_protect_b,
	output logic             serial_out,
	output logic             serial_out_en_b,
	output logic [13:0]      array_addr,
	input  wire logic [7:0]  array_rd_data,
	output logic             array_wr_en,
	output logic [7:0]       array_wr_data
);
	typedef struct packed {
		logic [2:0]                         cs_sync;
		logic [2:0]                         clk_sync;
		logic [1:0]                         din_sync;
		logic [1:0]                         wp_sync;
		eeprom_pkg::frame_state_e           frame;
		logic [2:0]                         bit_cnt;
		logic [7:0]                         rx;
		logic [7:0]                         tx;
		logic [7:0]                         cmd;
		logic                               addr_hi_done;
		logic [13:0]                        addr;
		logic                               have_data;
		logic                               accept;
		logic                               pend_lock;
		logic [1:0]                         pend_protect;
		logic                               status_lock;
		logic [1:0]                         protect;
		logic                               latch;
		eeprom_pkg::cycle_kind_e            kind;
		logic [eeprom_pkg::TIMER_WIDTH-1:0] timer;
		logic                               flush;
		logic                               out_bit;
		logic                               out_en_b;
		logic                               wr_en;
		logic [7:0]                         wr_data;
	} core_state_s;

	localparam logic [eeprom_pkg::TIMER_WIDTH-1:0] TIMER_LOAD =
		eeprom_pkg::TIMER_WIDTH'(WRITE_CYCLES);

	core_state_s               s_reg;
	core_state_s               s_next;
	eeprom_pkg::write_entry_s  fifo_in;
	eeprom_pkg::write_entry_s  fifo_out;
	logic                      fifo_push;
	logic                      fifo_in_ready;
	logic                      fifo_out_valid;
	logic                      fifo_out_ready;
	logic                      cs_b;
	logic                      cs_rise;
	logic                      cs_fall;
	logic                      clk_rise;
	logic                      clk_fall;
	logic                      busy;
	logic                      hardware_protect_mode;
	logic [7:0]                rx_byte;
	logic                      byte_done;
	logic [7:0]                status_byte;
	logic [13:0]               full_addr;

	// synchronised pin views and edges
	assign cs_b      = s_reg.cs_sync[1];
	assign cs_rise   = s_reg.cs_sync[1] && !s_reg.cs_sync[2];
	assign cs_fall   = !s_reg.cs_sync[1] && s_reg.cs_sync[2];
	assign clk_rise  = s_reg.clk_sync[1] && !s_reg.clk_sync[2];
	assign clk_fall  = !s_reg.clk_sync[1] && s_reg.clk_sync[2];
	assign rx_byte   = {s_reg.rx[6:0], s_reg.din_sync[1]};
	assign byte_done = clk_rise && (s_reg.bit_cnt == eeprom_pkg::BIT_LAST);
	// busy while any self-timed cycle runs
	assign busy      = s_reg.kind != eeprom_pkg::CYCLE_NONE;
	// hardware protect from lock bit and pin
	// combinational, so whichever comes last enters it
	assign hardware_protect_mode       = s_reg.status_lock && !s_reg.wp_sync[1];
	// only the low fourteen address bits are kept
	assign full_addr = {s_reg.addr[13:8], rx_byte};

	// bits 6 to 4 read as zero
	always_comb begin
		status_byte = '0;
		status_byte[eeprom_pkg::STATUS_LOCK_POS]  = s_reg.status_lock;
		status_byte[eeprom_pkg::PROTECT_HIGH_POS] = s_reg.protect[1];
		status_byte[eeprom_pkg::PROTECT_LOW_POS]  = s_reg.protect[0];
		status_byte[eeprom_pkg::LATCH_POS]        = s_reg.latch;
		status_byte[eeprom_pkg::BUSY_POS]         = busy;
	end

	// protected region check on the start address
	function automatic logic is_protected(input logic [1:0] prot, input logic [13:0] a);
		logic hit;
		hit = 1'b1;
		if (prot == eeprom_pkg::PROTECT_NONE) begin
			hit = 1'b0;
		end else if (prot == eeprom_pkg::PROTECT_QUARTER) begin
			hit = a >= eeprom_pkg::QUARTER_BASE;
		end else if (prot == eeprom_pkg::PROTECT_HALF) begin
			hit = a >= eeprom_pkg::HALF_BASE;
		end
		return hit;
	endfunction

	// buffer for array write bytes, drained during the timed cycle
	assign fifo_in        = '{addr: s_reg.addr, data: rx_byte};
	assign fifo_out_ready = (s_reg.kind == eeprom_pkg::CYCLE_ARRAY) || s_reg.flush;
	assign fifo_push      = !cs_b && !cs_fall && byte_done
		&& (s_reg.frame == eeprom_pkg::FRAME_WRITE_DATA) && s_reg.accept;

	word_fifo #(
		.WIDTH ($bits(eeprom_pkg::write_entry_s)),
		.DEPTH (eeprom_pkg::FIFO_DEPTH)
	) write_buffer (
		.clock     (clock),
		.rst_b     (rst_b),
		.in_valid  (fifo_push),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_in),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out)
	);

	// next-state logic: pin sync, timed cycle, frame decoding
	always_comb begin
		s_next = s_reg;
		s_next.cs_sync  = {s_reg.cs_sync[1:0], chip_select_b};
		s_next.clk_sync = {s_reg.clk_sync[1:0], serial_clock};
		s_next.din_sync = {s_reg.din_sync[0], serial_in};
		s_next.wp_sync  = {s_reg.wp_sync[0], write_protect_b};
		s_next.wr_en    = 1'b0;
		if (s_reg.flush && !fifo_out_valid) begin
			s_next.flush = 1'b0;
		end
		// self-timed cycle: count down and drain the buffer into the array
		if (busy) begin
			if (s_reg.timer != '0) begin
				s_next.timer = s_reg.timer - 1'b1;
			end
			if (s_reg.kind == eeprom_pkg::CYCLE_ARRAY && fifo_out_valid) begin
				s_next.wr_en   = 1'b1;
				s_next.addr    = fifo_out.addr;
				s_next.wr_data = fifo_out.data;
			end
			if (s_reg.timer == '0 && !fifo_out_valid) begin
				// new protection bits land only at the very end
				if (s_reg.kind == eeprom_pkg::CYCLE_STATUS) begin
					s_next.status_lock = s_reg.pend_lock;
					s_next.protect     = s_reg.pend_protect;
				end
				// latch clears when either write cycle completes
				s_next.latch = 1'b0;
				s_next.kind  = eeprom_pkg::CYCLE_NONE;
			end
		end
		if (cs_b) begin
			// deselect ends a read at any bit
			s_next.out_en_b = 1'b1;
			s_next.frame    = eeprom_pkg::FRAME_IDLE;
			if (cs_rise) begin
				// framed status write starts its cycle at deselect
				// needs the latch; lock clear ignores the pin
				if (s_reg.frame == eeprom_pkg::FRAME_STATUS_DATA && s_reg.have_data
					&& s_reg.bit_cnt == '0 && s_reg.latch && !hardware_protect_mode && !busy) begin
					s_next.kind  = eeprom_pkg::CYCLE_STATUS;
					s_next.timer = TIMER_LOAD;
				// array write starts only on a byte boundary
				end else if (s_reg.frame == eeprom_pkg::FRAME_WRITE_DATA && s_reg.accept
					&& s_reg.have_data && s_reg.bit_cnt == '0) begin
					s_next.kind  = eeprom_pkg::CYCLE_ARRAY;
					s_next.timer = TIMER_LOAD;
				end else if (s_reg.frame == eeprom_pkg::FRAME_WRITE_DATA) begin
					s_next.flush = 1'b1;
				end
			end
		end else if (cs_fall) begin
			s_next.frame   = eeprom_pkg::FRAME_COMMAND;
			s_next.bit_cnt = '0;
		end else begin
			// input taken on rising serial clock edges
			if (clk_rise) begin
				s_next.rx      = rx_byte;
				s_next.bit_cnt = s_reg.bit_cnt + 1'b1;
			end
			case (s_reg.frame)
				eeprom_pkg::FRAME_COMMAND: begin
					if (byte_done) begin
						s_next.cmd          = rx_byte;
						s_next.have_data    = 1'b0;
						s_next.addr_hi_done = 1'b0;
						// single-byte commands end in the wait state
						s_next.frame        = eeprom_pkg::FRAME_WAIT;
						if (rx_byte == eeprom_pkg::CMD_WRITE_ENABLE) begin
							s_next.latch = busy ? s_next.latch : 1'b1; // keep a cycle-end clear
						end else if (rx_byte == eeprom_pkg::CMD_WRITE_DISABLE) begin
							s_next.latch = busy ? s_next.latch : 1'b0;
						// status read taken even while busy
						end else if (rx_byte == eeprom_pkg::CMD_STATUS_READ) begin
							s_next.frame = eeprom_pkg::FRAME_STATUS_OUT;
						end else if (rx_byte == eeprom_pkg::CMD_STATUS_WRITE && !busy) begin
							s_next.frame = eeprom_pkg::FRAME_STATUS_DATA;
						end else if ((rx_byte == eeprom_pkg::CMD_ARRAY_READ
							|| rx_byte == eeprom_pkg::CMD_ARRAY_WRITE) && !busy) begin
							s_next.frame = eeprom_pkg::FRAME_ADDRESS;
						end
						// anything else stays in the wait state
					end
				end
				eeprom_pkg::FRAME_ADDRESS: begin
					if (byte_done && !s_reg.addr_hi_done) begin
						s_next.addr[13:8]   = rx_byte[eeprom_pkg::ADDR_HI_BITS-1:0];
						s_next.addr_hi_done = 1'b1;
					end else if (byte_done) begin
						// address register loaded from the command
						s_next.addr   = full_addr;
						s_next.frame  = (s_reg.cmd == eeprom_pkg::CMD_ARRAY_READ)
							? eeprom_pkg::FRAME_READ : eeprom_pkg::FRAME_WRITE_DATA;
						// no latch, no write; protected region refused
						s_next.accept = s_reg.latch
							&& !is_protected(s_reg.protect, full_addr);
					end
				end
				eeprom_pkg::FRAME_READ, eeprom_pkg::FRAME_STATUS_OUT: begin
					// output changes on falling serial clock edges
					if (clk_fall && s_reg.bit_cnt == '0) begin
						s_next.out_en_b = 1'b0;
						if (s_reg.frame == eeprom_pkg::FRAME_READ) begin
							// address steps and wraps past the top
							s_next.tx      = array_rd_data;
							s_next.out_bit = array_rd_data[7];
							s_next.addr    = s_reg.addr + 1'b1;
						end else begin
							s_next.tx      = status_byte;
							s_next.out_bit = status_byte[7];
						end
					end else if (clk_fall) begin
						s_next.tx      = {s_reg.tx[6:0], 1'b0};
						s_next.out_bit = s_reg.tx[6];
					end
				end
				eeprom_pkg::FRAME_STATUS_DATA: begin
					// any clock beyond the data byte spoils the frame
					if (clk_rise && s_reg.have_data) begin
						s_next.frame = eeprom_pkg::FRAME_WAIT;
					end else if (byte_done) begin
						// only lock and protect bits are taken
						s_next.pend_lock    = rx_byte[eeprom_pkg::STATUS_LOCK_POS];
						s_next.pend_protect = {rx_byte[eeprom_pkg::PROTECT_HIGH_POS],
							rx_byte[eeprom_pkg::PROTECT_LOW_POS]};
						s_next.have_data    = 1'b1;
					end
				end
				eeprom_pkg::FRAME_WRITE_DATA: begin
					// bytes beyond a full buffer are dropped
					if (byte_done) begin
						s_next.have_data = 1'b1;
						if (s_reg.accept && fifo_in_ready) begin
							s_next.addr = s_reg.addr + 1'b1;
						end
					end
				end
				default: begin
				end
			endcase
		end
	end

	// state register; pins idle high for select, low for the clock
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			s_reg          <= '0;
			s_reg.cs_sync  <= 3'h7;
			s_reg.wp_sync  <= 2'h3;
			s_reg.out_en_b <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	// outputs straight from flops
	assign serial_out      = s_reg.out_bit;
	assign serial_out_en_b = s_reg.out_en_b;
	assign array_addr      = s_reg.addr;
	assign array_wr_en     = s_reg.wr_en;
	assign array_wr_data   = s_reg.wr_data;

	// checks on the command logic
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	sequence disable_taken;
		!cs_b && !cs_fall && s_reg.frame == eeprom_pkg::FRAME_COMMAND && byte_done
			&& rx_byte == eeprom_pkg::CMD_WRITE_DISABLE && !busy;
	endsequence
	sequence read_while_busy;
		!cs_b && !cs_fall && s_reg.frame == eeprom_pkg::FRAME_COMMAND && byte_done
			&& rx_byte == eeprom_pkg::CMD_ARRAY_READ && busy;
	endsequence

	chk_disable_clears_latch: assert property (disable_taken |=> !s_reg.latch && s_reg.frame == eeprom_pkg::FRAME_WAIT) else $error("write-disable left latch or frame wrong");
	chk_read_busy_ignored: assert property (read_while_busy |=> s_reg.frame == eeprom_pkg::FRAME_WAIT) else $error("array read accepted while busy");
	chk_no_latch_reject: assert property (cs_rise && !s_reg.latch && !busy |=> !busy) else $error("write started without latch");
	chk_zero_status_bits: assert property (status_byte[6:4] == 3'h0 && status_byte[0] == busy) else $error("status byte layout wrong");
	chk_hpm_blocks_status: assert property (cs_rise && hardware_protect_mode && s_reg.kind != eeprom_pkg::CYCLE_STATUS |=> s_reg.kind != eeprom_pkg::CYCLE_STATUS) else $error("status write ran in hardware protect");
	chk_cycle_end_latch: assert property ($fell(busy) |-> !s_reg.latch) else $error("latch still set after write cycle");
	chk_bits_held_busy: assert property (busy && $past(busy) |-> $stable(s_reg.protect) && $stable(s_reg.status_lock)) else $error("protection bits changed mid cycle");
	chk_read_addr_wrap: assert property (s_reg.frame == eeprom_pkg::FRAME_READ && !cs_b && !cs_fall && clk_fall && s_reg.bit_cnt == '0 && s_reg.addr == eeprom_pkg::ADDR_LAST |=> s_reg.addr == '0) else $error("read address did not wrap");
	chk_released_deselect: assert property (cs_b |=> serial_out_en_b) else $error("output driven while deselected");
endmodule
`default_nettype wire

//--- verilog/eeprom_pkg.sv
// shared constants and types for the serial eeprom command logic
package eeprom_pkg;

	// command byte codes
	localparam logic [7:0] CMD_WRITE_ENABLE  = 8'h06;
	localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] CMD_STATUS_READ   = 8'h05;
	localparam logic [7:0] CMD_STATUS_WRITE  = 8'h01;
	localparam logic [7:0] CMD_ARRAY_READ    = 8'h03;
	localparam logic [7:0] CMD_ARRAY_WRITE   = 8'h02;

	// array addressing and protected regions
	localparam int          ADDR_WIDTH   = 14;
	localparam int          ADDR_HI_BITS = 6;
	localparam logic [13:0] ADDR_LAST    = 14'h3fff;
	localparam logic [13:0] QUARTER_BASE = 14'h3000;
	localparam logic [13:0] HALF_BASE    = 14'h2000;
	localparam logic [1:0]  PROTECT_NONE    = 2'h0;
	localparam logic [1:0]  PROTECT_QUARTER = 2'h1;
	localparam logic [1:0]  PROTECT_HALF    = 2'h2;

	// status byte field positions
	localparam int STATUS_LOCK_POS   = 7;
	localparam int PROTECT_HIGH_POS  = 3;
	localparam int PROTECT_LOW_POS   = 2;
	localparam int LATCH_POS         = 1;
	localparam int BUSY_POS          = 0;

	// self-timed write cycle length
	localparam int WRITE_TIME_NS        = 5000000;
	localparam int CLOCK_PERIOD_NS      = 4;
	localparam int WRITE_CYCLES_DEFAULT = WRITE_TIME_NS / CLOCK_PERIOD_NS;
	localparam int TIMER_WIDTH          = 21;

	// write data buffer
	localparam int FIFO_DEPTH = 8;
	localparam logic [2:0] BIT_LAST = 3'h7;

	typedef struct packed {
		logic [13:0] addr;
		logic [7:0]  data;
	} write_entry_s;

	typedef enum logic [2:0] {
		FRAME_IDLE, FRAME_COMMAND, FRAME_ADDRESS, FRAME_READ,
		FRAME_STATUS_OUT, FRAME_WRITE_DATA, FRAME_STATUS_DATA, FRAME_WAIT
	} frame_state_e;

	typedef enum logic [1:0] {
		CYCLE_NONE, CYCLE_ARRAY, CYCLE_STATUS
	} cycle_kind_e;

endpackage

//--- verilog/word_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
	parameter int WIDTH = 22,
	parameter int DEPTH = 8
) (
	input  wire logic             clock,
	input  wire logic             rst_b,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
	localparam logic [PW:0]   COUNT_FULL = (PW + 1)'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               wr_ptr;
		logic [PW-1:0]               rd_ptr;
		logic [PW:0]                 count;
	} fifo_state_s;

	fifo_state_s s_reg;
	fifo_state_s s_next;
	logic        push;
	logic        pop;

	// honest full and empty flags
	assign in_ready  = s_reg.count != COUNT_FULL;
	assign out_valid = s_reg.count != '0;
	assign out_data  = s_reg.mem[s_reg.rd_ptr];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// pointer and storage update
	always_comb begin
		s_next = s_reg;
		if (push) begin
			s_next.mem[s_reg.wr_ptr] = in_data;
			s_next.wr_ptr = (s_reg.wr_ptr == PTR_LAST) ? '0 : s_reg.wr_ptr + 1'b1;
		end
		if (pop) begin
			s_next.rd_ptr = (s_reg.rd_ptr == PTR_LAST) ? '0 : s_reg.rd_ptr + 1'b1;
		end
		if (push && !pop) begin
			s_next.count = s_reg.count + 1'b1;
		end else if (pop && !push) begin
			s_next.count = s_reg.count - 1'b1;
		end
	end

	// state register
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end
endmodule
`default_nettype wire

//--- dv/spi_host_model.sv
// spi host model: mode 0 frames paced by the system clock
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	input  wire logic clock,
	output logic      chip_select_b,
	output logic      serial_clock,
	output logic      serial_in,
	input  wire logic serial_line
);
	// half a link period, 8 system clocks, inputs moved 1 ns after the edge
	task automatic half;
		repeat (8) @(posedge clock);
		#1;
	endtask

	// one frame: nbits from the top of tx, replies sampled at each rise
	// msb first, command then address then data
	task automatic xfer(input logic [127:0] tx, input int nbits, output logic [127:0] rx);
		rx = '0;
		chip_select_b = 1'b0;
		for (int i = 0; i < nbits; i++) begin
			serial_in = tx[127-i];
			half();
			serial_clock = 1'b1;
			rx[127-i] = serial_line;
			half();
			serial_clock = 1'b0;
		end
		// deselect after the last latched bit, clock idle low
		half();
		chip_select_b = 1'b1;
		serial_in = ~serial_in; // released line no longer shows the last bit
		repeat (4) half();
	endtask

	// idle bus at time zero
	initial begin
		chip_select_b = 1'b1;
		serial_clock = 1'b0;
		serial_in = 1'b0;
	end
endmodule
`default_nettype wire

//--- dv/tb.sv
// self-checking bench for the serial eeprom command logic
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic         clock;
	logic         rst_b;
	logic         chip_select_b;
	logic         serial_clock;
	logic         serial_in;
	logic         write_protect_b;
	logic         serial_out;
	logic         serial_out_en_b;
	logic         serial_line;
	logic [13:0]  array_addr;
	logic [7:0]   array_rd_data;
	logic         array_wr_en;
	logic [7:0]   array_wr_data;
	logic [7:0]   mem [0:16383];
	logic [13:0]  wa_q [$];
	logic [7:0]   wd_q [$];
	int           err_total;
	int           check_count;
	int           low_count;
	int           low_seen;
	logic [127:0] rx;

	spi_eeprom_core #(.WRITE_CYCLES(1000)) spi_eeprom_core_i (
		.clock(clock), .rst_b(rst_b), .chip_select_b(chip_select_b),
		.serial_clock(serial_clock), .serial_in(serial_in),
		.write_protect_b(write_protect_b), .serial_out(serial_out),
		.serial_out_en_b(serial_out_en_b), .array_addr(array_addr),
		.array_rd_data(array_rd_data), .array_wr_en(array_wr_en),
		.array_wr_data(array_wr_data)
	);
	spi_host_model spi_host_model_i (
		.clock(clock), .chip_select_b(chip_select_b), .serial_clock(serial_clock),
		.serial_in(serial_in), .serial_line(serial_line)
	);

	// a released output shows the inverse of its last value
	assign serial_line = serial_out_en_b ? ~serial_out : serial_out;

	// clock at 4 ns
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	// array storage: registered read, writes logged, drive cycles counted
	always @(posedge clock) begin
		array_rd_data <= mem[array_addr];
		if (serial_out_en_b === 1'b0) low_count <= low_count + 1;
		if (array_wr_en === 1'b1) begin
			mem[array_addr] <= array_wr_data;
			wa_q.push_back(array_addr);
			wd_q.push_back(array_wr_data);
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic send(input logic [127:0] tx, input int nbits);
		spi_host_model_i.xfer(tx, nbits, rx);
	endtask

	task automatic write_enable_command;
		send({eeprom_pkg::CMD_WRITE_ENABLE, 120'h0}, 8);
	endtask

	// status sent twice in one frame, output released afterwards
	task automatic rd_status(input logic [7:0] exp);
		send({eeprom_pkg::CMD_STATUS_READ, 120'h0}, 24);
		chk("status twice", {16'h0, exp, exp}, {16'h0, rx[119:104]});
		chk("out released", 32'h1, {31'h0, serial_out_en_b});
	endtask

	// poll the busy flag before any new command
	task automatic wait_idle;
		for (int i = 0; i < 40; i++) begin
			send({eeprom_pkg::CMD_STATUS_READ, 120'h0}, 16);
			if (rx[112] === 1'b0) break;
		end
		chk("busy cleared", 32'h0, {31'h0, rx[112]});
	endtask

	task automatic wrap_up;
		$display("checks %0d, mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// watchdog well beyond the expected run
	initial begin
		#200us;
		err_total++;
		wrap_up();
	end

	initial begin
		err_total = 0;
		check_count = 0;
		rst_b = 1'b0;
		write_protect_b = 1'b1;
		for (int i = 0; i < 16384; i++) mem[i] = i[7:0] ^ 8'h5a;
		repeat (10) @(posedge clock);
		#1;
		rst_b = 1'b1;
		repeat (4) @(posedge clock);
		#1;
		rd_status(8'h00);
		write_enable_command();
		rd_status(8'h02);
		send(128'hff05 << 112, 16);
		rd_status(8'h02);
		send({eeprom_pkg::CMD_WRITE_DISABLE, 120'h0}, 16);
		rd_status(8'h00);
		send({eeprom_pkg::CMD_STATUS_WRITE, 8'hff, 112'h0}, 16);
		rd_status(8'h00);
		// status write with lock clear and protect pin low
		write_protect_b = 1'b0;
		write_enable_command();
		send({eeprom_pkg::CMD_STATUS_WRITE, 8'hff, 112'h0}, 16);
		rd_status(8'h03);
		wait_idle();
		rd_status(8'h8c);
		write_enable_command();
		send({eeprom_pkg::CMD_STATUS_WRITE, 120'h0}, 16);
		rd_status(8'h8e);
		write_protect_b = 1'b1;
		send({eeprom_pkg::CMD_STATUS_WRITE, 120'h0}, 16);
		wait_idle();
		rd_status(8'h00);
		write_enable_command();
		send({eeprom_pkg::CMD_STATUS_WRITE, 8'h04, 112'h0}, 16);
		wait_idle();
		write_enable_command();
		send({eeprom_pkg::CMD_ARRAY_WRITE, 16'h3ffe, 8'h77, 96'h0}, 32);
		rd_status(8'h06);
		// nine bytes offered, the buffer keeps eight
		send({eeprom_pkg::CMD_ARRAY_WRITE, 16'h0ffe, 72'ha0a1a2a3a4a5a6a7a8, 32'h0}, 96);
		low_seen = low_count;
		send({eeprom_pkg::CMD_ARRAY_READ, 16'h0ffe, 104'h0}, 32);
		chk("drive while busy", low_seen, low_count);
		wait_idle();
		rd_status(8'h04);
		chk("write pulses", 32'h8, 32'(wa_q.size()));
		for (int i = 0; i < 8 && i < wa_q.size(); i++) begin
			chk("write addr", 32'h0ffe + i, {18'h0, wa_q[i]});
			chk("write data", 32'ha0 + i, {24'h0, wd_q[i]});
		end
		send({eeprom_pkg::CMD_ARRAY_READ, 16'h0ffe, 104'h0}, 56);
		chk("read bytes", 32'ha0a1a2a3, rx[103:72]);
		// wrap past the top, then deselect mid-byte
		send({eeprom_pkg::CMD_ARRAY_READ, 16'hffff, 104'h0}, 43);
		chk("wrap bytes", 32'ha55a, {16'h0, rx[103:88]});
		rd_status(8'h04);
		write_enable_command();
		send({eeprom_pkg::CMD_ARRAY_WRITE, 16'h0ffe, 8'h55, 96'h0}, 36);
		rd_status(8'h06);
		chk("write pulses", 32'h8, 32'(wa_q.size()));
		// upper half protected: 2000 refused, 1fff written
		send({eeprom_pkg::CMD_STATUS_WRITE, 8'h08, 112'h0}, 16);
		wait_idle();
		write_enable_command();
		send({eeprom_pkg::CMD_ARRAY_WRITE, 16'h2000, 8'h3c, 96'h0}, 32);
		rd_status(8'h0a);
		send({eeprom_pkg::CMD_ARRAY_WRITE, 16'h1fff, 8'h3c, 96'h0}, 32);
		wait_idle();
		rd_status(8'h08);
		chk("write pulses", 32'h9, 32'(wa_q.size()));
		chk("write addr", 32'h1fff, {18'h0, wa_q[8]});
		chk("write data", 32'h3c, {24'h0, wd_q[8]});
		wrap_up();
	end
endmodule
`default_nettype wire
